/* logic/ir_timer_defines.svh */
// Register offsets, field positions and reset values for the infrared timer
`ifndef IR_TIMER_DEFINES_SVH
`define IR_TIMER_DEFINES_SVH
`define IRT_ADDR_W         4
`define IRT_OFF_CARRIER    4'h0
`define IRT_OFF_MODTIME    4'h1
`define IRT_OFF_COUNTER    4'h2
`define IRT_OFF_CONTROL    4'h3
`define IRT_OFF_STATUS     4'h4
`define IRT_OFF_PINCTL     4'h5
`define IRT_CTL_ENABLE     0
`define IRT_CTL_TXMODE     1
`define IRT_CTL_POL        2
`define IRT_CTL_FINE       3
`define IRT_CTL_DATA       4
`define IRT_CTL_RELOAD     5
`define IRT_CTL_BURST      6
`define IRT_CTL_INTEN      7
`define IRT_CTL_EDGE_LO    8
`define IRT_CTL_ENV_LO     10
`define IRT_CTL_DIV_LO     12
`define IRT_ST_INTFLAG     0
`define IRT_ST_ROLL        1
`define IRT_PIN_LEVEL      0
`define IRT_PIN_OE         1
`define IRT_RST_WORD       16'h0000
`define IRT_BURST_PRESET   16'h0001
`define IRT_ENV_MOD        2'h1
`define IRT_ENV_CW         2'h2
`define IRT_EDGE_FALL      2'h1
`define IRT_EDGE_RISE      2'h2
`define IRT_EDGE_BOTH      2'h3
`endif

/* logic/ir_timer_pkg.sv */
// Types shared by the infrared timer files
`default_nettype none
package ir_timer_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_TX   = 3'b010,
    ST_RX   = 3'b100
  } ir_state_e;
  typedef struct packed {
    logic [2:0] div;
    logic [1:0] env;
    logic [1:0] edge_sel;
    logic       int_en;
    logic       burst;
    logic       reload;
    logic       data;
    logic       fine;
    logic       pol;
    logic       tx_mode;
    logic       enable;
  } ir_ctl_s;
  typedef struct packed {
    logic [15:0] carrier;
    logic [15:0] modtime;
    logic        data;
    logic        pol;
  } ir_latch_s;
endpackage : ir_timer_pkg
`default_nettype wire

/* logic/ir_carrier_gen.sv */
// Carrier generator: prescaler tick, high and low phase counter
`timescale 1ns/1ps
`default_nettype none
module ir_carrier_gen (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // Control
  input  wire logic        i_run,
  input  wire logic [2:0]  i_div,
  input  wire logic [7:0]  i_high,
  input  wire logic [7:0]  i_low,
  // Outputs
  output logic             o_tick,
  output logic             o_carrier,
  output logic             o_cycle_end
);
  logic [6:0] pre_reg;
  logic [6:0] pre_next;
  logic [7:0] ph_reg;
  logic [7:0] ph_next;
  logic       hi_reg;
  logic       hi_next;
  logic       tick_c;
  logic [6:0] pre_max;
  // Input clock is system clock over two to the divider field
  always_comb begin
    pre_max  = 7'((8'h01 << i_div) - 8'h01);
    tick_c   = i_run && (pre_reg == pre_max);
    pre_next = (!i_run || tick_c) ? 7'h00 : pre_reg + 7'h01;
    ph_next  = ph_reg;
    hi_next  = hi_reg;
    if (!i_run) begin
      ph_next = 8'h00;
      hi_next = 1'b1;
    end else if (tick_c) begin
      if (ph_reg == (hi_reg ? i_high : i_low)) begin
        ph_next = 8'h00;
        hi_next = !hi_reg;
      end else begin
        ph_next = ph_reg + 8'h01;
      end
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      pre_reg <= 7'h00;
      ph_reg  <= 8'h00;
      hi_reg  <= 1'b1;
    end else begin
      pre_reg <= pre_next;
      ph_reg  <= ph_next;
      hi_reg  <= hi_next;
    end
  end
  // High for high byte plus one ticks, low for low byte plus one
  assign o_tick      = tick_c;
  assign o_carrier   = hi_reg;
  assign o_cycle_end = tick_c && !hi_reg && (ph_reg == i_low);
endmodule : ir_carrier_gen
`default_nettype wire

/* logic/ir_timer.sv */
// Infrared carrier generation, modulation and capture timer
//
// Local design decisions: the register offsets and the strobed register port.
`include "ir_timer_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ir_timer (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // Register port
  input  wire logic [3:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [15:0]      o_rdata,
  // Infrared pins
  input  wire logic        i_rx_pin,
  output logic             o_tx_pin,
  output logic             o_tx_pin_oe,
  output logic             o_envelope_pin,
  // Interrupt request
  output logic             o_irq
);
  ir_timer_pkg::ir_ctl_s   ctl_reg, ctl_next;
  ir_timer_pkg::ir_latch_s lat_reg, lat_next;
  ir_timer_pkg::ir_state_e st_reg, st_next;
  logic [15:0] carrier_timing_reg, carrier_timing_next;
  logic [15:0] modulation_time_reg, modulation_time_next;
  logic [15:0] interval_counter_reg, interval_counter_next;
  logic        data_reg, data_next;
  logic        int_flag_reg, int_flag_next;
  logic        roll_reg, roll_next;
  logic        man_level_reg, man_level_next;
  logic        man_oe_reg, man_oe_next;
  logic        started_reg, started_next;
  logic [16:0] gap_reg, gap_next;
  logic        rx_prev_reg;
  logic        tx_reg, tx_next;
  logic        env_reg, env_next;
  logic        irq_reg;
  logic [15:0] rdata_reg, rdata_next;
  logic        tick;
  logic        carrier;
  logic        cyc_end;
  logic        step;
  logic        qual;
  logic        rise;
  logic        fall;
  logic        wr_ctl;
  ir_timer_pkg::ir_ctl_s wctl;
  // Edge qualification shared by receive capture and burst counting
  function automatic logic edge_ok(input logic [1:0] sel, input logic r, input logic f);
    edge_ok = ((sel == `IRT_EDGE_FALL) && f) || ((sel == `IRT_EDGE_RISE) && r) ||
              ((sel == `IRT_EDGE_BOTH) && (r || f));
  endfunction : edge_ok
  // Carrier runs from latched timing in transmit, live timing in receive
  ir_carrier_gen u_carrier (
    .i_clk       (i_clk),
    .i_rstn      (i_rstn),
    .i_run       (st_reg != ir_timer_pkg::ST_IDLE),
    .i_div       (ctl_reg.div),
    .i_high      (st_reg == ir_timer_pkg::ST_TX ? lat_reg.carrier[15:8] : carrier_timing_reg[15:8]),
    .i_low       (st_reg == ir_timer_pkg::ST_TX ? lat_reg.carrier[7:0] : carrier_timing_reg[7:0]),
    .o_tick      (tick),
    .o_carrier   (carrier),
    .o_cycle_end (cyc_end)
  );
  // Counter clock is carrier cycle or input clock
  assign step   = ctl_reg.fine ? tick : cyc_end;
  assign rise   = i_rx_pin && !rx_prev_reg;
  assign fall   = !i_rx_pin && rx_prev_reg;
  assign qual   = (st_reg == ir_timer_pkg::ST_RX) && edge_ok(ctl_reg.edge_sel, rise, fall);
  assign wr_ctl = i_wr && (i_addr == `IRT_OFF_CONTROL);
  assign wctl   = ir_timer_pkg::ir_ctl_s'(i_wdata[14:0]);
  always_comb begin
    ctl_next              = wr_ctl ? wctl : ctl_reg;
    carrier_timing_next   = (i_wr && i_addr == `IRT_OFF_CARRIER) ? i_wdata : carrier_timing_reg;
    modulation_time_next  = (i_wr && i_addr == `IRT_OFF_MODTIME) ? i_wdata : modulation_time_reg;
    interval_counter_next = (i_wr && i_addr == `IRT_OFF_COUNTER) ? i_wdata : interval_counter_reg;
    data_next             = wr_ctl ? wctl.data : data_reg;
    man_level_next        = man_level_reg;
    man_oe_next           = man_oe_reg;
    if (i_wr && i_addr == `IRT_OFF_PINCTL) begin
      man_level_next = i_wdata[`IRT_PIN_LEVEL];
      man_oe_next    = i_wdata[`IRT_PIN_OE];
    end
    // Write one to clear; hardware set below wins
    int_flag_next = int_flag_reg;
    roll_next     = roll_reg;
    if (i_wr && i_addr == `IRT_OFF_STATUS) begin
      int_flag_next = int_flag_reg && !i_wdata[`IRT_ST_INTFLAG];
      roll_next     = roll_reg && !i_wdata[`IRT_ST_ROLL];
    end
    lat_next     = lat_reg;
    started_next = started_reg;
    gap_next     = gap_reg;
    tx_next      = tx_reg;
    env_next     = env_reg;
    st_next      = st_reg;
    // Mode follows enable and mode bits; software stops by clearing enable
    if (!ctl_next.enable) st_next = ir_timer_pkg::ST_IDLE;
    else if (ctl_next.tx_mode) st_next = ir_timer_pkg::ST_TX;
    else st_next = ir_timer_pkg::ST_RX;
    case (st_reg)
      ir_timer_pkg::ST_TX: begin
        if (step) begin
          if (interval_counter_reg == `IRT_RST_WORD) begin
            // Reload and resample at interval boundary
            interval_counter_next = modulation_time_reg;
            lat_next      = '{carrier_timing_reg, modulation_time_reg, data_reg, ctl_reg.pol};
            int_flag_next = 1'b1;
            env_next      = data_reg ^ ctl_reg.pol;
          end else begin
            interval_counter_next = interval_counter_reg - 16'h0001;
          end
        end
      end
      ir_timer_pkg::ST_RX: begin
        if (qual) begin
          if (!started_reg) begin
            started_next          = 1'b1;
            interval_counter_next = `IRT_RST_WORD;
          end else begin
            if (ctl_reg.burst) begin
              modulation_time_next = modulation_time_reg + 16'h0001;
            end else begin
              data_next            = rise;
              modulation_time_next = interval_counter_reg;
              int_flag_next        = 1'b1;
            end
            if (ctl_reg.reload) interval_counter_next = `IRT_RST_WORD;
            else if (step) interval_counter_next = interval_counter_reg + 16'h0001;
          end
          gap_next = 17'h0_0000;
        end else if (started_reg && step) begin
          interval_counter_next = interval_counter_reg + 16'h0001;
          if (interval_counter_reg == 16'hFFFF) roll_next = 1'b1;
        end
        // Two carrier periods with no edge mark a space
        if (!qual && started_reg && cyc_end && ctl_reg.burst && gap_reg != 17'h0_0002) begin
          gap_next = gap_reg + 17'h0_0001;
          if (gap_reg == 17'h0_0001) int_flag_next = 1'b1;
        end
      end
      default: begin
        started_next = 1'b0;
        gap_next     = 17'h0_0000;
      end
    endcase
    // A software write to the counter must land even while it is counting
    if (i_wr && i_addr == `IRT_OFF_COUNTER) interval_counter_next = i_wdata;
    if (st_next != ir_timer_pkg::ST_RX) started_next = 1'b0;
    // Entering transmit latches the live settings
    if (st_next == ir_timer_pkg::ST_TX && st_reg != ir_timer_pkg::ST_TX) begin
      lat_next              = '{carrier_timing_next, modulation_time_next, data_next, ctl_next.pol};
      interval_counter_next = modulation_time_next;
      env_next              = data_next ^ ctl_next.pol;
    end
    if (wr_ctl && wctl.burst && !ctl_reg.burst) modulation_time_next = `IRT_BURST_PRESET;
    // Pin drive: manual when off, else idle level or carrier
    if (st_next == ir_timer_pkg::ST_IDLE) tx_next = man_level_next;
    else if (st_next == ir_timer_pkg::ST_RX) tx_next = ctl_next.pol;
    else if (ctl_reg.env == `IRT_ENV_CW && st_reg == ir_timer_pkg::ST_TX)
      tx_next = carrier ^ lat_reg.pol;
    else if (st_reg == ir_timer_pkg::ST_TX && lat_next.data)
      tx_next = carrier ^ lat_next.pol;
    else tx_next = lat_next.pol;
    rdata_next = 16'h0000;
    if (i_rd) begin
      case (i_addr)
        `IRT_OFF_CARRIER: rdata_next = carrier_timing_reg;
        `IRT_OFF_MODTIME: rdata_next = modulation_time_reg;
        `IRT_OFF_COUNTER: rdata_next = interval_counter_reg;
        `IRT_OFF_CONTROL: rdata_next = {1'b0, ctl_reg[14:5], data_reg, ctl_reg[3:0]};
        `IRT_OFF_STATUS:  rdata_next = {14'h0000, roll_reg, int_flag_reg};
        `IRT_OFF_PINCTL:  rdata_next = {14'h0000, man_oe_reg, man_level_reg};
        default:          rdata_next = 16'h0000;
      endcase
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      ctl_reg              <= '0;
      lat_reg              <= '0;
      st_reg               <= ir_timer_pkg::ST_IDLE;
      carrier_timing_reg   <= `IRT_RST_WORD;
      modulation_time_reg  <= `IRT_RST_WORD;
      interval_counter_reg <= `IRT_RST_WORD;
      data_reg             <= 1'b0;
      int_flag_reg         <= 1'b0;
      roll_reg             <= 1'b0;
      man_level_reg        <= 1'b0;
      man_oe_reg           <= 1'b0;
      started_reg          <= 1'b0;
      gap_reg              <= 17'h0_0000;
      rx_prev_reg          <= 1'b1;
      tx_reg               <= 1'b0;
      env_reg              <= 1'b0;
      irq_reg              <= 1'b0;
      rdata_reg            <= 16'h0000;
      o_tx_pin_oe          <= 1'b0;
    end else begin
      ctl_reg              <= ctl_next;
      lat_reg              <= lat_next;
      st_reg               <= st_next;
      carrier_timing_reg   <= carrier_timing_next;
      modulation_time_reg  <= modulation_time_next;
      interval_counter_reg <= interval_counter_next;
      data_reg             <= data_next;
      int_flag_reg         <= int_flag_next;
      roll_reg             <= roll_next;
      man_level_reg        <= man_level_next;
      man_oe_reg           <= man_oe_next;
      started_reg          <= started_next;
      gap_reg              <= gap_next;
      rx_prev_reg          <= i_rx_pin;
      tx_reg               <= tx_next;
      env_reg              <= env_next;
      irq_reg              <= (int_flag_next || roll_next) && ctl_next.int_en;
      rdata_reg            <= rdata_next;
      o_tx_pin_oe          <= (st_next != ir_timer_pkg::ST_IDLE) || man_oe_next;
    end
  end
  assign o_tx_pin       = tx_reg;
  assign o_envelope_pin = env_reg;
  assign o_irq          = irq_reg;
  assign o_rdata        = rdata_reg;
  // Assertions
  AST_IDLE_MANUAL: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (st_reg == ir_timer_pkg::ST_IDLE && $past(st_next) == ir_timer_pkg::ST_IDLE)
      |-> o_tx_pin == man_level_reg) else $error("manual level not on pin");
  AST_IRQ_AND: assert property (@(posedge i_clk) disable iff (!i_rstn)
    ##1 o_irq == $past((int_flag_next || roll_next) && ctl_next.int_en))
    else $error("irq mismatch");
  AST_FLAG_STICK: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (int_flag_reg && !(i_wr && i_addr == `IRT_OFF_STATUS)) |=> int_flag_reg)
    else $error("flag dropped");
  AST_DISABLE_IDLE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !ctl_next.enable |=> st_reg == ir_timer_pkg::ST_IDLE) else $error("runs while off");
  AST_TX_RELOAD: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (st_reg == ir_timer_pkg::ST_TX && st_next == ir_timer_pkg::ST_TX && step &&
     interval_counter_reg == 16'h0000) |=> (int_flag_reg && lat_reg.modtime ==
     $past(modulation_time_reg))) else $error("no reload at zero");
  AST_BURST_PRESET: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (wr_ctl && wctl.burst && !ctl_reg.burst) |=> modulation_time_reg == 16'h0001)
    else $error("burst preset missing");
  AST_ROLL: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (st_reg == ir_timer_pkg::ST_RX && started_reg && step && !qual &&
     interval_counter_reg == 16'hFFFF) |=> roll_reg) else $error("rollover missed");
  AST_CAPTURE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (qual && started_reg && !ctl_reg.burst && st_next == ir_timer_pkg::ST_RX && !i_wr)
      |=> (modulation_time_reg == $past(interval_counter_reg) && data_reg == $past(rise)))
    else $error("capture wrong");
endmodule : ir_timer
`default_nettype wire

/* verif/ir_far_side.sv */
// Far-side model: IR receiver output toggling on a fixed cadence
`timescale 1ns/1ps
`default_nettype none
module ir_far_side (
  // Clock
  input  wire logic       i_clk,
  // Cadence control
  input  wire logic       i_run,
  input  wire logic [7:0] i_gap,
  // Demodulated receive level
  output logic            o_rx
);
  logic [7:0] cnt_reg = 8'h00;
  logic       rx_reg  = 1'b1;
  assign o_rx = rx_reg;
  // Counter restarts when stopped so that toggle counts stay exact
  always @(posedge i_clk) begin
    cnt_reg <= (i_run && cnt_reg != i_gap - 8'h01) ? cnt_reg + 8'h01 : 8'h00;
    if (i_run && cnt_reg == i_gap - 8'h01) begin
      rx_reg <= ~rx_reg;
    end
  end
endmodule : ir_far_side
`default_nettype wire

/* verif/ir_timer_tb.sv */
// Self-checking bench for the infrared timer
`include "ir_timer_defines.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module ir_timer_tb;
  typedef struct packed {
    logic       pol;
    logic       data;
    logic [1:0] env;
    logic [7:0] highs;
    logic       env_pin;
  } tx_row_s;
  // Carrier 3 high, 2 low: 30 highs in 50 cycles, 20 when inverted
  tx_row_s     rows [7] = '{'{0, 1, 1, 8'h1E, 1}, '{1, 1, 1, 8'h14, 0},
                            '{1, 0, 0, 8'h32, 1}, '{0, 0, 0, 8'h00, 0},
                            '{0, 0, 2, 8'h1E, 0}, '{1, 0, 2, 8'h14, 1},
                            '{0, 1, 2, 8'h1E, 1}};
  logic        i_clk = 1'b0;
  logic        i_rstn, i_wr, i_rd, run, rx;
  logic [3:0]  i_addr;
  logic [15:0] i_wdata, o_rdata, d, m0, ctl;
  logic [7:0]  gap, hi;
  logic        o_tx_pin, o_tx_pin_oe, o_envelope_pin, o_irq;
  int          error_cnt = 0;
  int          n_tests = 0;
  int          cyc = 0;
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) cyc <= cyc + 1;
  ir_timer i_ir_timer (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_pin(rx), .o_tx_pin(o_tx_pin),
    .o_tx_pin_oe(o_tx_pin_oe), .o_envelope_pin(o_envelope_pin), .o_irq(o_irq));
  ir_far_side i_ir_far_side (.i_clk(i_clk), .i_run(run), .i_gap(gap), .o_rx(rx));
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge i_clk);
    i_addr <= a; i_wdata <= v; i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge i_clk);
    i_addr <= a; i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask : rd
  task automatic w_irq(output int c);
    for (int k = 0; k < 400 && o_irq !== 1'b1; k++) begin
      @(posedge i_clk); #1;
    end
    c = cyc;
  endtask : w_irq
  // Clear both flags, then let the registered request fall
  task automatic clr;
    wr(`IRT_OFF_STATUS, 16'h0003);
    repeat (2) @(posedge i_clk);
    #1;
  endtask : clr
  task automatic spacing(input logic [15:0] c, input int exp);
    int t1, t2;
    wr(`IRT_OFF_CONTROL, 16'h0000); wr(`IRT_OFF_CONTROL, c);
    w_irq(t1); clr; w_irq(t1); clr; w_irq(t2);
    `CHK(t2 - t1, exp)
  endtask : spacing
  task automatic pulse_rx(input int n);
    @(posedge i_clk);
    run <= 1'b1;
    repeat (n) @(posedge i_clk);
    run <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask : pulse_rx
  task report_and_stop;
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (30000) @(posedge i_clk);
    error_cnt++;
    report_and_stop;
  end
  initial begin
    i_rstn = 1'b0; i_addr = 4'h0; i_wdata = 16'h0000; i_wr = 1'b0; i_rd = 1'b0;
    run = 1'b0; gap = 8'h28;
    repeat (20) @(posedge i_clk);
    i_rstn <= 1'b1;
    #1 `CHK({o_tx_pin, o_tx_pin_oe, o_envelope_pin, o_irq}, 4'h0)
    for (int a = 0; a < 7; a++) begin
      rd(4'(a), d); `CHK(d, 16'h0000)
    end
    // Index 6 is unmapped, pin control holds two bits
    for (int a = 0; a < 7; a++) if (a != 3 && a != 4) begin
      wr(4'(a), 16'h5A3F); rd(4'(a), d);
      `CHK(d, (a == 6) ? 16'h0000 : (a == 5) ? 16'h0003 : 16'h5A3F)
    end
    `CHK({o_tx_pin, o_tx_pin_oe}, 2'b11)
    wr(`IRT_OFF_PINCTL, 16'h0002); repeat (2) @(posedge i_clk);
    #1 `CHK({o_tx_pin, o_tx_pin_oe}, 2'b01)
    wr(`IRT_OFF_CARRIER, 16'h0201); wr(`IRT_OFF_MODTIME, 16'h0003);
    foreach (rows[r]) begin
      ctl = {4'h0, rows[r].env, 5'h00, rows[r].data, 1'b0, rows[r].pol, 2'b10};
      wr(`IRT_OFF_CONTROL, 16'h0000);
      wr(`IRT_OFF_STATUS, 16'h0003);
      // Odd rows enable in receive first, then select transmit
      if (r % 2) wr(`IRT_OFF_CONTROL, (ctl & 16'hFFFD) | 16'h0001);
      wr(`IRT_OFF_CONTROL, ctl | 16'h0001);
      repeat (10) @(posedge i_clk);
      hi = 8'h00;
      repeat (50) begin
        @(posedge i_clk); #1 hi = hi + o_tx_pin;
      end
      `CHK(hi, rows[r].highs)
      `CHK({o_envelope_pin, o_tx_pin_oe, o_irq}, {rows[r].env_pin, 2'b10})
      rd(`IRT_OFF_STATUS, d); `CHK(d[0], 1'b1)
    end
    spacing(16'h0083, 20);
    spacing(16'h208B, 16);
    // Receive: both edges, reload on capture, fine timing, interrupt on
    wr(`IRT_OFF_CONTROL, 16'h0000); wr(`IRT_OFF_STATUS, 16'h0003);
    wr(`IRT_OFF_CONTROL, 16'h03A9);
    pulse_rx(200);
    rd(`IRT_OFF_MODTIME, d);
    `CHK(d >= 16'h0027 && d <= 16'h0028, 1'b1)
    rd(`IRT_OFF_CONTROL, d); `CHK(d[4], rx)
    rd(`IRT_OFF_STATUS, d); `CHK({d[0], o_irq}, 2'b11)
    clr; wr(`IRT_OFF_COUNTER, 16'hFFF0); repeat (30) @(posedge i_clk);
    rd(`IRT_OFF_STATUS, d); `CHK({d[1:0], o_irq}, 3'b101)
    // No edge selected: captures must not happen
    wr(`IRT_OFF_CONTROL, 16'h00A9); wr(`IRT_OFF_MODTIME, 16'h1234);
    pulse_rx(100);
    rd(`IRT_OFF_MODTIME, d); `CHK(d, 16'h1234)
    wr(`IRT_OFF_CONTROL, 16'h02A9); pulse_rx(160);
    rd(`IRT_OFF_CONTROL, d); `CHK(d[4], 1'b1)
    // Burst count: rising edges every 4 cycles, carrier period 8
    wr(`IRT_OFF_CARRIER, 16'h0303); wr(`IRT_OFF_CONTROL, 16'h0201);
    wr(`IRT_OFF_CONTROL, 16'h0241); gap <= 8'h02;
    rd(`IRT_OFF_MODTIME, m0); `CHK(m0, `IRT_BURST_PRESET)
    wr(`IRT_OFF_STATUS, 16'h0003); pulse_rx(20);
    rd(`IRT_OFF_MODTIME, d); `CHK(d, m0 + 16'h0005)
    rd(`IRT_OFF_STATUS, d); `CHK(d[0], 1'b0)
    repeat (40) @(posedge i_clk);
    rd(`IRT_OFF_STATUS, d); `CHK(d[0], 1'b1)
    // Disabled: counter frozen, pin back under manual control
    wr(`IRT_OFF_CONTROL, 16'h0000); rd(`IRT_OFF_COUNTER, m0);
    repeat (20) @(posedge i_clk);
    rd(`IRT_OFF_COUNTER, d); `CHK(d, m0)
    `CHK({o_tx_pin, o_tx_pin_oe}, 2'b01)
    report_and_stop;
  end
endmodule : ir_timer_tb
`default_nettype wire
